// [include/cmpo_pkg.sv]
// Shared widths and reset values for the comparator output control block
package cmpo_pkg;
   localparam int SEL_W = 2;                    // Input select field width
   localparam int HYS_W = 2;                    // Hysteresis field width
   localparam int RSP_W = 2;                    // Response time field width
   localparam logic [SEL_W-1:0] SEL_RST = 2'h0; // Input select reset value
   localparam logic [HYS_W-1:0] HYS_RST = 2'h0; // Hysteresis reset value
   localparam logic [RSP_W-1:0] RSP_RST = 2'h0; // Response time reset value
   localparam logic             BIT_RST = 1'h0; // Single control bit reset
   localparam int SYNC_STAGES = 2;              // Synchroniser depth
   localparam int LAT_DELAY   = 3;              // Raw to latched edges
endpackage : cmpo_pkg

// [include/cmpo_sync_if.sv]
// Carrier between the control top and its synchroniser
`timescale 1ns/1ps
interface cmpo_sync_if;
   logic async_in;
   logic sync_out;
   modport ctrl (output async_in, input sync_out);
   modport sync (input async_in, output sync_out);
endinterface : cmpo_sync_if

// [design/cmpo_sync.sv]
// Two-flop synchroniser for the raw comparator decision
`timescale 1ns/1ps
module cmpo_sync (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   cmpo_sync_if.sync port
);
   logic meta_q;
   logic sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         meta_q <= cmpo_pkg::BIT_RST;
         sync_q <= cmpo_pkg::BIT_RST;
      end else begin
         meta_q <= port.async_in;
         sync_q <= meta_q;
      end
   end

   assign port.sync_out = sync_q;
endmodule : cmpo_sync

// [design/cmpo_top.sv]
// Comparator output control: selects, sync path, edge flags, pin drive
`timescale 1ns/1ps
module cmpo_top (
   input  wire logic                         i_clk,
   input  wire logic                         i_sys_rst,
   input  wire logic                         i_cmp_raw,
   input  wire logic                         i_cmp_enable_bit,
   input  wire logic [cmpo_pkg::SEL_W-1:0]   i_pos_input_select,
   input  wire logic [cmpo_pkg::SEL_W-1:0]   i_neg_input_select,
   input  wire logic [cmpo_pkg::RSP_W-1:0]   i_resp_mode,
   input  wire logic [cmpo_pkg::HYS_W-1:0]   i_hyst_pos,
   input  wire logic [cmpo_pkg::HYS_W-1:0]   i_hyst_neg,
   input  wire logic                         i_rise_clr,
   input  wire logic                         i_fall_clr,
   input  wire logic                         i_reset_src_en,
   input  wire logic                         i_pin_route_raw,
   input  wire logic                         i_pin_push_pull,
   output logic                              o_cmp_enabled,
   output logic [cmpo_pkg::SEL_W-1:0]        o_pos_input_select,
   output logic [cmpo_pkg::SEL_W-1:0]        o_neg_input_select,
   output logic [cmpo_pkg::RSP_W-1:0]        o_resp_mode,
   output logic [cmpo_pkg::HYS_W-1:0]        o_hyst_pos,
   output logic [cmpo_pkg::HYS_W-1:0]        o_hyst_neg,
   output logic                              o_raw_cmp_out,
   output logic                              o_latched_cmp_out,
   output logic                              o_rise_edge_flag,
   output logic                              o_fall_edge_flag,
   output logic                              o_reset_req,
   output logic                              o_pin_out,
   output logic                              o_pin_oe_n
);
   logic        en_q;
   logic        route_raw_q;
   logic        push_pull_q;
   logic        raw_gated;
   logic        sync_val;
   logic        pin_val;
   logic        rise_ev;
   logic        fall_ev;
   logic [1:0]  since_rst_q;

   cmpo_sync_if sif ();

   // Enable and pin configuration held in flops
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         en_q        <= cmpo_pkg::BIT_RST;
         route_raw_q <= cmpo_pkg::BIT_RST;
         push_pull_q <= cmpo_pkg::BIT_RST;
      end else begin
         en_q        <= i_cmp_enable_bit;
         route_raw_q <= i_pin_route_raw;
         push_pull_q <= i_pin_push_pull;
      end
   end
   assign o_cmp_enabled = en_q;

   // Analog mux selects and tuning fields for the comparator core
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_pos_input_select <= cmpo_pkg::SEL_RST;
         o_neg_input_select <= cmpo_pkg::SEL_RST;
         o_resp_mode        <= cmpo_pkg::RSP_RST;
         o_hyst_pos         <= cmpo_pkg::HYS_RST;
         o_hyst_neg         <= cmpo_pkg::HYS_RST;
      end else begin
         o_pos_input_select <= i_pos_input_select;
         o_neg_input_select <= i_neg_input_select;
         o_resp_mode        <= i_resp_mode;
         o_hyst_pos         <= i_hyst_pos;
         o_hyst_neg         <= i_hyst_neg;
      end
   end

   // Raw path is deliberately gate-only: it must work with no clock edge
   assign raw_gated     = en_q & i_cmp_raw;
   assign o_raw_cmp_out = raw_gated;

   // Synchronised copy of the gated decision
   assign sif.async_in = raw_gated;
   assign sync_val     = sif.sync_out;

   cmpo_sync cmpo_sync_i (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .port      (sif)
   );

   // Edge events against the last latched value
   assign rise_ev = sync_val & ~o_latched_cmp_out;
   assign fall_ev = ~sync_val & o_latched_cmp_out;

   // Latched output, one flop after the synchroniser
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_latched_cmp_out <= cmpo_pkg::BIT_RST;
      end else begin
         o_latched_cmp_out <= sync_val;
      end
   end

   // Sticky flags; an edge in the clearing cycle wins
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rise_edge_flag <= cmpo_pkg::BIT_RST;
         o_fall_edge_flag <= cmpo_pkg::BIT_RST;
      end else begin
         o_rise_edge_flag <= rise_ev | (o_rise_edge_flag & ~i_rise_clr);
         o_fall_edge_flag <= fall_ev | (o_fall_edge_flag & ~i_fall_clr);
      end
   end

   // Reset request while enabled and the synchronised result is low
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_reset_req <= cmpo_pkg::BIT_RST;
      end else begin
         o_reset_req <= i_reset_src_en & en_q & ~sync_val;
      end
   end

   // Pin drive; raw route stays combinational so it survives stop mode
   // Gated by enable so a stale latched one never leaks to the pin
   assign pin_val    = en_q &
                       (route_raw_q ? raw_gated : o_latched_cmp_out);
   assign o_pin_out  = pin_val;
   assign o_pin_oe_n = ~(push_pull_q | ~pin_val);

   // Cycles since reset release, for assertions only
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         since_rst_q <= 2'h0;
      end else if (since_rst_q != 2'h3) begin
         since_rst_q <= since_rst_q + 2'h1;
      end
   end

   // Checks run on the system clock and pause while reset is held
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   chk_rise_flag_set: assert property (
      rise_ev |=> (o_rise_edge_flag && o_latched_cmp_out))
      else $error("rise flag not set on rising edge");
   chk_fall_flag_set: assert property (
      fall_ev |=> (o_fall_edge_flag && !o_latched_cmp_out))
      else $error("fall flag not set on falling edge");
   chk_rise_flag_hold: assert property (
      (o_rise_edge_flag && !i_rise_clr) |=> o_rise_edge_flag)
      else $error("rise flag dropped without clear");
   chk_fall_flag_clear: assert property (
      (i_fall_clr && !fall_ev) |=> !o_fall_edge_flag)
      else $error("fall flag not cleared");
   chk_disabled_low: assert property (
      !en_q |-> (!o_raw_cmp_out && !o_pin_out))
      else $error("disabled comparator drives high");
   chk_enable_follow: assert property (
      $rose(i_cmp_enable_bit) |=> o_cmp_enabled)
      else $error("enable bit not taken");
   chk_pos_select: assert property (
      ##1 o_pos_input_select == $past(i_pos_input_select))
      else $error("positive select not applied");
   chk_neg_select: assert property (
      ##1 o_neg_input_select == $past(i_neg_input_select))
      else $error("negative select not applied");
   chk_latched_delay: assert property (
      (since_rst_q == 2'h3) |-> o_latched_cmp_out == $past(raw_gated, 3))
      else $error("latched output not three edges behind raw");
   chk_reset_source: assert property (
      (i_reset_src_en && en_q && !sync_val) |=> o_reset_req)
      else $error("reset request missing");
   chk_pin_open_drain: assert property (
      (!push_pull_q && pin_val) |-> o_pin_oe_n)
      else $error("open-drain pin driven high");
   chk_pin_push_pull: assert property (
      push_pull_q |-> !o_pin_oe_n)
      else $error("push-pull pin not driven");
   chk_rise_flag_clear: assert property (
      (i_rise_clr && !rise_ev) |=> !o_rise_edge_flag)
      else $error("rise flag not cleared");
   chk_fall_flag_hold: assert property (
      (o_fall_edge_flag && !i_fall_clr) |=> o_fall_edge_flag)
      else $error("fall flag dropped without clear");
   chk_pin_route_raw: assert property (
      (en_q && route_raw_q) |-> (o_pin_out == o_raw_cmp_out))
      else $error("pin does not carry raw output");
   chk_pin_route_lat: assert property (
      (en_q && !route_raw_q) |-> (o_pin_out == o_latched_cmp_out))
      else $error("pin does not carry latched output");
   chk_raw_follow: assert property (
      en_q |-> (o_raw_cmp_out == i_cmp_raw))
      else $error("raw output does not follow comparison");
   chk_hyst_fields: assert property (
      ##1 {o_hyst_pos, o_hyst_neg} == $past({i_hyst_pos, i_hyst_neg}))
      else $error("hysteresis codes not applied");
   chk_enable_drop: assert property (
      $fell(i_cmp_enable_bit) |=> !o_cmp_enabled)
      else $error("enable clear not taken");
   chk_reset_release: assert property (
      (!i_reset_src_en || !en_q || sync_val) |=> !o_reset_req)
      else $error("reset request without cause");

   // Main scenarios the bench is expected to reach
   cov_rise: cover property (rise_ev ##1 o_rise_edge_flag);
   cov_fall_clear: cover property (o_fall_edge_flag ##1 i_fall_clr);
   cov_raw_pin: cover property (route_raw_q && push_pull_q && pin_val);
   cov_reset_req: cover property (o_reset_req);
   cov_open_drain: cover property (!push_pull_q && pin_val && o_pin_oe_n);
endmodule : cmpo_top

// [bench/tb_cmpo_top.sv]
// Self-checking bench for the comparator output control block
`timescale 1ns/1ps
module tb_cmpo_top;
   logic                       i_clk, i_sys_rst, i_cmp_raw, i_cmp_enable_bit;
   logic [cmpo_pkg::SEL_W-1:0] i_pos_input_select, i_neg_input_select;
   logic [cmpo_pkg::RSP_W-1:0] i_resp_mode;
   logic [cmpo_pkg::HYS_W-1:0] i_hyst_pos, i_hyst_neg;
   logic                       i_rise_clr, i_fall_clr, i_reset_src_en;
   logic                       i_pin_route_raw, i_pin_push_pull, clk_run;
   logic                       o_cmp_enabled, o_raw_cmp_out, o_latched_cmp_out;
   logic [cmpo_pkg::SEL_W-1:0] o_pos_input_select, o_neg_input_select;
   logic [cmpo_pkg::RSP_W-1:0] o_resp_mode;
   logic [cmpo_pkg::HYS_W-1:0] o_hyst_pos, o_hyst_neg;
   logic                       o_rise_edge_flag, o_fall_edge_flag, o_reset_req;
   logic                       o_pin_out, o_pin_oe_n;
   int                         failures, samples_checked;

   cmpo_top cmpo_top_i (.i_clk, .i_sys_rst, .i_cmp_raw, .i_cmp_enable_bit,
      .i_pos_input_select, .i_neg_input_select, .i_resp_mode, .i_hyst_pos,
      .i_hyst_neg, .i_rise_clr, .i_fall_clr, .i_reset_src_en,
      .i_pin_route_raw, .i_pin_push_pull, .o_cmp_enabled,
      .o_pos_input_select, .o_neg_input_select, .o_resp_mode, .o_hyst_pos,
      .o_hyst_neg, .o_raw_cmp_out, .o_latched_cmp_out, .o_rise_edge_flag,
      .o_fall_edge_flag, .o_reset_req, .o_pin_out, .o_pin_oe_n);

   // Clock can be frozen to show the raw path needs no clock
   initial begin
      i_clk = 1'h0;
      forever #4 if (clk_run) i_clk = ~i_clk;
   end

   task automatic check(input string name, input logic [3:0] seen,
                        input logic [3:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(negedge i_clk);
   endtask : step

   task automatic conclude();
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude

   // Main sequence; inputs move on the falling edge until the clock is frozen
   initial begin
      {i_cmp_raw, i_cmp_enable_bit, i_rise_clr, i_fall_clr} = 4'h0;
      {i_reset_src_en, i_pin_route_raw, i_pin_push_pull} = 3'h0;
      {i_pos_input_select, i_neg_input_select, i_resp_mode} = 6'h00;
      {i_hyst_pos, i_hyst_neg} = 4'h0;
      failures = 0;
      samples_checked = 0;
      clk_run = 1'h1;
      i_sys_rst = 1'h1;
      step(20);
      i_sys_rst = 1'h0;
      check("flags", {o_rise_edge_flag, o_fall_edge_flag}, 4'h0);
      // Every code of each select and tuning field is passed through
      for (int v = 0; v < 4; v++) begin
         i_pos_input_select = 2'(v);
         i_neg_input_select = 2'(3 - v);
         i_resp_mode = 2'(v);
         i_hyst_pos = 2'(v ^ 1);
         i_hyst_neg = 2'(~v);
         step(1);
         check("pos_sel", o_pos_input_select, 4'(v));
         check("neg_sel", o_neg_input_select, 4'(3 - v));
         check("resp", o_resp_mode, 4'(v));
         check("hyst", {o_hyst_pos, o_hyst_neg}, {2'(v ^ 1), 2'(~v)});
      end
      i_cmp_raw = 1'h1;
      step(1);
      check("raw_dis", o_raw_cmp_out, 4'h0);
      i_cmp_raw = 1'h0;
      i_cmp_enable_bit = 1'h1;
      step(4);
      check("enabled", o_cmp_enabled, 4'h1);
      // Rising result: raw at once, latched after three edges
      i_cmp_raw = 1'h1;
      #1 check("raw_on", o_raw_cmp_out, 4'h1);
      step(2);
      check("lat_early", o_latched_cmp_out, 4'h0);
      step(1);
      check("lat_rise", o_latched_cmp_out, 4'h1);
      check("rise", o_rise_edge_flag, 4'h1);
      i_cmp_raw = 1'h0;
      step(6);
      check("sticky", {o_rise_edge_flag, o_fall_edge_flag}, 4'h3);
      i_rise_clr = 1'h1;
      step(1);
      i_rise_clr = 1'h0;
      check("rise_clr", {o_rise_edge_flag, o_fall_edge_flag}, 4'h1);
      i_fall_clr = 1'h1;
      i_reset_src_en = 1'h1;
      step(1);
      i_fall_clr = 1'h0;
      step(2);
      check("fall_clr", o_fall_edge_flag, 4'h0);
      check("rst_low", o_reset_req, 4'h1);
      i_cmp_raw = 1'h1;
      i_pin_route_raw = 1'h1;
      i_pin_push_pull = 1'h1;
      step(5);
      check("rst_high", o_reset_req, 4'h0);
      check("pp", {o_pin_out, o_pin_oe_n}, 4'h2);
      i_pin_push_pull = 1'h0;
      step(1);
      check("od_high", {o_pin_out, o_pin_oe_n}, 4'h3);
      i_pin_route_raw = 1'h0;
      step(1);
      check("pin_lat", o_pin_out, 4'h1);
      // Disable forces the raw, latched and pin outputs low and records the fall
      i_cmp_enable_bit = 1'h0;
      step(5);
      check("dis_out", {o_raw_cmp_out, o_latched_cmp_out}, 4'h0);
      check("dis_pin", {o_pin_out, o_pin_oe_n}, 4'h0);
      check("dis_fall", o_fall_edge_flag, 4'h1);
      i_cmp_enable_bit = 1'h1;
      i_pin_route_raw = 1'h1;
      step(3);
      // Clock frozen low: raw path and pin keep following the input
      clk_run = 1'h0;
      i_cmp_raw = 1'h0;
      #20 check("stop_lo", {o_raw_cmp_out, o_pin_out}, 4'h0);
      i_cmp_raw = 1'h1;
      #20 check("stop_hi", {o_raw_cmp_out, o_pin_out}, 4'h3);
      clk_run = 1'h1;
      step(2);
      conclude();
   end
endmodule : tb_cmpo_top
